// ### sgd_diag.sv
// diagnostic record, interrupt window and microsecond stamp
`timescale 1ns/1ps
module sgd_diag (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // parameterization
   input wire logic diag_irq_enable,
   // fault causes, levels
   input wire logic module_failure,
   input wire logic external_error,
   input wire logic aux_supply_missing,
   input wire logic diag_buffer_overflow,
   input wire logic internal_comm_error,
   input wire logic param_error,
   input wire logic excitation_short,
   input wire logic range_underflow,
   input wire logic range_overflow,
   // record read request
   input wire logic rd_req,
   input wire logic rd_use_od,
   input wire logic [7:0] record_set_index,
   input wire logic [15:0] object_dictionary_index,
   input wire logic [4:0] rd_byte,
   // record read answer
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic rd_error,
   // interrupt and indicator
   output logic irq_incoming,
   output logic irq_going,
   output logic fault_indicator
);
   import sgd_pkg::*;

   // state and held record
   sgd_state_type state_r, state_nxt;
   logic [7:0] mod_r, mod_nxt; // module byte without channel bit
   logic [7:0] int_r, int_nxt; // internal byte
   logic [7:0] ch_r, ch_nxt; // channel 0 error byte
   logic [31:0] stamp_r, stamp_nxt;
   logic [31:0] us_count_r; // free-running microseconds
   logic [4:0] div_r; // clock divider toward 1 us
   logic inc_r, go_r, led_r;
   logic rd_valid_r, rd_error_r;
   logic [7:0] rd_data_r;

   // live cause bytes
   wire [7:0] live_mod;
   wire [7:0] live_int;
   wire [7:0] live_ch;
   assign live_mod = {param_error, 2'b00, aux_supply_missing, 1'b0,
      external_error, 1'b0, module_failure};
   assign live_int = {3'b000, internal_comm_error, diag_buffer_overflow,
      3'b000};
   assign live_ch = {range_overflow, range_underflow, 2'b00,
      excitation_short, 2'b00, param_error};
   // any cause present; every one of these causes is a trigger
   wire live_any = (|live_mod) | (|live_int) | (|live_ch);
   wire rec_any = (|mod_r) | (|int_r) | (|ch_r);

   // inside the window a held flag may only fall with its cause
   wire [7:0] kept_mod = mod_r & live_mod;
   wire [7:0] kept_int = int_r & live_int;
   wire [7:0] kept_ch = ch_r & live_ch;
   wire kept_any = (|kept_mod) | (|kept_int) | (|kept_ch);
   wire tick = (div_r == 5'(US_CYCLES - 1));
   wire start_win = diag_irq_enable & live_any;

   // next record and window state
   always_comb begin
      state_nxt = state_r;
      mod_nxt = live_mod;
      int_nxt = live_int;
      ch_nxt = live_ch;
      stamp_nxt = stamp_r;
      case (state_r)
         ST_IDLE: begin
            // stamp when a fault appears, enabled or not
            if (live_any && !rec_any) begin
               stamp_nxt = us_count_r;
            end
            if (start_win) begin
               state_nxt = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            // new events are dropped until the going interrupt
            mod_nxt = kept_mod;
            int_nxt = kept_int;
            ch_nxt = kept_ch;
            if (!kept_any) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // window state and held record
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         mod_r <= FLAGS_RESET;
         int_r <= FLAGS_RESET;
         ch_r <= FLAGS_RESET;
         stamp_r <= STAMP_RESET;
      end else begin
         state_r <= state_nxt;
         mod_r <= mod_nxt;
         int_r <= int_nxt;
         ch_r <= ch_nxt;
         stamp_r <= stamp_nxt;
      end
   end

   // interrupt pulses and indicator, all registered
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         inc_r <= 1'b0;
         go_r <= 1'b0;
         led_r <= 1'b0;
      end else begin
         inc_r <= (state_r == ST_IDLE) && start_win;
         go_r <= (state_r == ST_ACTIVE) && !kept_any;
         led_r <= (state_nxt == ST_ACTIVE);
      end
   end

   // microsecond ticker from a divide-by-25 enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_r <= 5'h00;
         us_count_r <= 32'h0000_0000;
      end else if (tick) begin
         div_r <= 5'h00;
         us_count_r <= us_count_r + 32'h0000_0001;
      end else begin
         div_r <= div_r + 5'h01;
      end
   end

   // record bytes, byte 0 in the low bits; stamp least byte first
   wire [7:0] summary = {7'h00, |ch_r};
   wire [7:0] mod_byte = mod_r | {4'h0, |summary, 3'b000};
   wire [255:0] rec_flat = {96'h0, stamp_r, 56'h0, ch_r, summary,
      NUM_CH, BITS_PER_CH, CHTYPE_AI, int_r, SPARE_RESET,
      CLASS_RESET, mod_byte};

   // index decode for both access paths
   wire want_full = rd_use_od ? (object_dictionary_index == OD_FULL)
      : (record_set_index == SET_FULL);
   wire want_short = rd_use_od ? (object_dictionary_index == OD_SHORT)
      : (record_set_index == SET_SHORT);
   wire [5:0] rd_len = want_full ? RECORD_LEN : SHORT_LEN;
   wire rd_ok = (want_full | want_short) && ({1'b0, rd_byte} < rd_len);
   wire [7:0] rd_sel = rec_flat[{rd_byte, 3'b000} +: 8];

   // read answer one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= 8'h00;
         rd_error_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_req;
         rd_data_r <= (rd_req && rd_ok) ? rd_sel : 8'h00;
         rd_error_r <= rd_req && !rd_ok;
      end
   end

   assign rd_valid = rd_valid_r;
   assign rd_data = rd_data_r;
   assign rd_error = rd_error_r;
   assign irq_incoming = inc_r;
   assign irq_going = go_r;
   assign fault_indicator = led_r;

   // checks, one clock domain, quiet while reset is held
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // interrupt only when enabled, and only once per window
   incoming_enabled_a: assert property (
      irq_incoming |-> $past(diag_irq_enable) && $past(live_any))
      else $error("incoming interrupt without enable");
   no_enable_quiet_a: assert property (
      (state_r == ST_IDLE && !diag_irq_enable) |=> !irq_incoming)
      else $error("incoming interrupt while disabled");
   single_incoming_a: assert property (
      irq_incoming |=> !irq_incoming)
      else $error("incoming interrupt repeated inside window");
   // going interrupt follows the last cause on its own
   going_auto_a: assert property (
      (state_r == ST_ACTIVE && !kept_any) |=> irq_going ##1 !irq_going)
      else $error("going interrupt missing after causes cleared");
   going_paired_a: assert property (
      irq_going |-> $past(state_r) == ST_ACTIVE)
      else $error("going interrupt without open window");
   // held flags may only fall while the window is open
   window_frozen_a: assert property (
      (state_r == ST_ACTIVE) |=> (ch_r & ~$past(ch_r)) == 8'h00)
      else $error("channel event recorded inside window");
   held_frozen_a: assert property (
      (state_r == ST_ACTIVE) |=> (mod_r & ~$past(mod_r)) == 8'h00
      && (int_r & ~$past(int_r)) == 8'h00)
      else $error("module event recorded inside window");
   // indicator is dark again in the going cycle itself
   indicator_on_a: assert property (
      irq_incoming |-> fault_indicator)
      else $error("indicator dark at incoming interrupt");
   indicator_span_a: assert property (
      irq_incoming |-> fault_indicator until irq_going)
      else $error("indicator dropped inside window");
   indicator_off_a: assert property (
      irq_going |-> !fault_indicator)
      else $error("indicator lit after going interrupt");
   // every listed trigger opens a window
   aux_trigger_a: assert property (
      (state_r == ST_IDLE && diag_irq_enable && aux_supply_missing)
      |=> irq_incoming)
      else $error("aux supply fault did not interrupt");
   trigger_set_a: assert property (
      (state_r == ST_IDLE && diag_irq_enable && (diag_buffer_overflow
      || internal_comm_error || param_error || range_underflow
      || range_overflow)) |=> irq_incoming)
      else $error("listed fault did not interrupt");
   // read port answers next cycle, refusals read zero
   read_answer_a: assert property (
      rd_req |=> rd_valid)
      else $error("read request not answered");
   short_limit_a: assert property (
      (rd_req && want_short && !want_full && rd_byte >= 5'h04)
      |=> rd_valid && rd_error)
      else $error("short index served past fourth byte");
   refused_zero_a: assert property (
      (rd_req && !rd_ok) |=> rd_valid && rd_error && rd_data == 8'h00)
      else $error("refused read returned data");
   // fixed bytes of the record
   class_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h01)
      |=> rd_data == 8'h15 && !rd_error)
      else $error("class byte wrong");
   kind_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h04)
      |=> rd_data == 8'h71)
      else $error("channel kind byte wrong");
   counts_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h06) |=> rd_data == 8'h01)
      else $error("channel count byte wrong");
   bits_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h05) |=> rd_data == 8'h08)
      else $error("bits per channel byte wrong");
   // flag bytes seen through the read port, reserved bits clear
   module_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h00) |=> rd_data[1] == 1'b0
      && rd_data[6:5] == 2'b00 && rd_data[3] == ($past(ch_r) != 8'h00))
      else $error("module byte layout wrong");
   internal_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h03)
      |=> rd_data[2:0] == 3'b000 && rd_data[7:5] == 3'b000)
      else $error("internal byte reserved bits set");
   summary_bit_a: assert property (
      (rd_req && want_full && rd_byte == 5'h07)
      |=> rd_data == {7'h00, ($past(ch_r) != 8'h00)})
      else $error("summary bit does not follow channel byte");
   channel_byte_a: assert property (
      (rd_req && want_full && rd_byte == 5'h08)
      |=> rd_data[2:1] == 2'b00 && rd_data[5:4] == 2'b00)
      else $error("channel byte reserved bits set");
   reserved_tail_a: assert property (
      (rd_req && want_full && rd_byte > 5'h08 && rd_byte < 5'h10)
      |=> rd_data == 8'h00)
      else $error("reserved channel bytes not zero");
   // stamp taken at the event and held through the window
   stamp_capture_a: assert property (
      irq_incoming && !$past(rec_any) |-> stamp_r == $past(us_count_r))
      else $error("time stamp not captured at event");
   stamp_held_a: assert property (
      (state_r == ST_ACTIVE) |=> $stable(stamp_r))
      else $error("time stamp changed inside window");
   // microsecond ticker steps once per divider wrap
   ticker_step_a: assert property (
      tick |=> us_count_r == $past(us_count_r) + 32'h0000_0001)
      else $error("microsecond counter did not step");
   ticker_hold_a: assert property (
      !tick |=> $stable(us_count_r))
      else $error("microsecond counter moved off tick");
   // flags follow causes, window closes with all clear
   flag_clear_a: assert property (
      (state_r == ST_IDLE && !live_any) |=> !rec_any)
      else $error("flag held after cause gone");
   going_clear_a: assert property (
      irq_going |-> !rec_any)
      else $error("flag still held at going interrupt");

   // main scenarios
   window_cover: cover property (irq_incoming ##[1:200] irq_going);
   od_read_cover: cover property (rd_req && rd_use_od && want_full);
   short_read_cover: cover property (rd_req && !rd_use_od && want_short);
   drop_cover: cover property (state_r == ST_ACTIVE && live_ch != ch_r);
   quiet_cover: cover property (state_r == ST_IDLE && !diag_irq_enable
      && live_any);
endmodule : sgd_diag

// ### sgd_diag_bench.sv
// self-checking bench for the diagnostic record block
`timescale 1ns/1ps
module sgd_diag_bench;
   import sgd_pkg::*;
   // table row: access and expected byte and refusal
   typedef logic [30:0] sgd_row_type;
   // cause row: two bytes to read and their values
   typedef logic [25:0] sgd_cause_type;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic diag_irq_enable = 1'b0;
   logic [8:0] cause = 9'h000; // port order, failure first
   logic rd_req, rd_use_od, rd_valid, rd_error;
   logic [7:0] record_set_index, rd_data, d;
   logic [15:0] object_dictionary_index;
   logic [4:0] rd_byte;
   logic irq_incoming, irq_going, fault_indicator, e, seen;
   logic [31:0] stamp;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   sgd_row_type rows [16] = '{
      {17'h00001, 5'h00, 9'h000}, {17'h00001, 5'h01, 9'h02a},
      {17'h00001, 5'h02, 9'h000}, {17'h00001, 5'h03, 9'h000},
      {17'h00001, 5'h04, 9'h0e2}, {17'h00001, 5'h05, 9'h010},
      {17'h00001, 5'h06, 9'h002}, {17'h00001, 5'h07, 9'h000},
      {17'h00001, 5'h08, 9'h000}, {17'h00001, 5'h10, 9'h000},
      {17'h00001, 5'h14, 9'h001}, {17'h00000, 5'h03, 9'h000},
      {17'h00000, 5'h04, 9'h001}, {17'h12f01, 5'h01, 9'h02a},
      {17'h12f00, 5'h04, 9'h001}, {17'h00002, 5'h00, 9'h001}};
   sgd_cause_type cs [9] = '{
      {5'h00, 8'h01, 5'h07, 8'h00}, {5'h00, 8'h04, 5'h07, 8'h00},
      {5'h00, 8'h10, 5'h03, 8'h00}, {5'h03, 8'h08, 5'h00, 8'h00},
      {5'h03, 8'h10, 5'h00, 8'h00}, {5'h08, 8'h01, 5'h00, 8'h88},
      {5'h08, 8'h08, 5'h00, 8'h08}, {5'h08, 8'h40, 5'h07, 8'h01},
      {5'h08, 8'h80, 5'h00, 8'h08}};
   sgd_diag u_sgd_diag (.clk, .reset_n, .diag_irq_enable,
      .module_failure(cause[0]), .external_error(cause[1]),
      .aux_supply_missing(cause[2]), .diag_buffer_overflow(cause[3]),
      .internal_comm_error(cause[4]), .param_error(cause[5]),
      .excitation_short(cause[6]), .range_underflow(cause[7]),
      .range_overflow(cause[8]), .rd_req, .rd_use_od, .record_set_index,
      .object_dictionary_index, .rd_byte, .rd_valid, .rd_data, .rd_error,
      .irq_incoming, .irq_going, .fault_indicator);
   sgd_head u_sgd_head (.clk, .rd_req, .rd_use_od, .record_set_index,
      .object_dictionary_index, .rd_byte, .rd_valid, .rd_data, .rd_error);
   // clock and cycles since reset release
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= reset_n ? cyc + 1 : 0;
   // single comparison point
   task automatic check(input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
   endtask : check
   // full record byte read
   task automatic rd(input logic [4:0] b);
      u_sgd_head.read_byte(1'b0, 16'h0001, b, d, e);
   endtask : rd
   // pulses last one cycle, so every cycle of the wait is watched
   task automatic wait_for(input logic inc);
      seen = 1'b0;
      repeat (4) begin
         @(negedge clk);
         if ((inc ? irq_incoming : irq_going) === 1'b1) seen = 1'b1;
      end
   endtask : wait_for
   // counts, verdict, end of run
   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // watchdog, far beyond the fewer than two hundred cycles needed
   initial begin
      #(40 * 20000);
      miscompares++;
      give_verdict();
   end
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      check({irq_incoming, irq_going, fault_indicator}, 0);
      // constant bytes, short and full views, refusals
      foreach (rows[i]) begin
         u_sgd_head.read_byte(rows[i][30], rows[i][29:14], rows[i][13:9],
            d, e);
         check({d, e}, rows[i][8:0]);
      end
      $display("test table done");
      // each cause opens a window, fills its bits, then closes it
      diag_irq_enable = 1'b1;
      for (int i = 0; i < 9; i++) begin
         n = cyc;
         cause[i] = 1'b1;
         wait_for(1'b1);
         check(seen, 1);
         check(fault_indicator, 1);
         rd(cs[i][25:21]);
         check(d, cs[i][20:13]);
         rd(cs[i][12:8]);
         check(d, cs[i][7:0]);
         if (i == 2) begin
            for (int k = 0; k < 4; k++) begin
               rd(5'(16 + k));
               stamp[8*k +: 8] = d;
            end
            check(stamp + 1 - 32'(n / 25) <= 2, 1);
            cause[8] = 1'b1;
            rd(5'h08);
            check(d, 8'h00);
            cause[8] = 1'b0;
         end
         cause[i] = 1'b0;
         wait_for(1'b0);
         check(seen, 1);
         check(fault_indicator, 0);
         rd(cs[i][25:21]);
         check(d, 8'h00);
      end
      $display("test causes done");
      // disabled: record tracks, no pulse, no indicator
      diag_irq_enable = 1'b0;
      cause[7] = 1'b1;
      wait_for(1'b1);
      check({seen, fault_indicator}, 0);
      rd(5'h08);
      check(d, 8'h40);
      // second reset in mid-run clears record and stamp
      reset_n = 1'b0;
      @(negedge clk);
      check({irq_incoming, irq_going, fault_indicator, rd_valid}, 0);
      cause[7] = 1'b0;
      reset_n = 1'b1;
      rd(5'h08);
      check(d, 8'h00);
      rd(5'h10);
      check(d, 8'h00);
      $display("test reset done");
      give_verdict();
   end
endmodule : sgd_diag_bench

// ### sgd_head.sv
// head station model that reads diagnostic record bytes
`timescale 1ns/1ps
module sgd_head (
   // clock
   input wire logic clk,
   // request lines, idle at time zero
   output logic rd_req = 1'b0,
   output logic rd_use_od = 1'b0,
   output logic [7:0] record_set_index = 8'h00,
   output logic [15:0] object_dictionary_index = 16'h0000,
   output logic [4:0] rd_byte = 5'h00,
   // answer lines
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   input wire logic rd_error
);
   // one byte; the request lives for exactly one taking edge
   task automatic read_byte(input logic od, input logic [15:0] idx,
      input logic [4:0] b, output logic [7:0] d, output logic e);
      @(negedge clk);
      rd_req = 1'b1;
      rd_use_od = od;
      record_set_index = idx[7:0];
      object_dictionary_index = idx;
      rd_byte = b;
      @(negedge clk);
      rd_req = 1'b0;
      // released lines show inverses so stale values never help
      rd_use_od = ~od;
      record_set_index = ~idx[7:0];
      object_dictionary_index = ~idx;
      rd_byte = ~b;
      // answer stands in the cycle after the taking edge
      d = rd_valid ? rd_data : 8'hxx;
      e = rd_valid ? rd_error : 1'bx;
   endtask : read_byte
endmodule : sgd_head

// ### sgd_pkg.sv
// constants for the strain-gauge diagnostic record and interrupt block
// What this block does
// - interrupt only when enabled; offer record then
// - going interrupt automatically once causes clear
// - events inside interrupt window are discarded
// - fault indicator lit from incoming to going
// - six listed fault conditions can trigger interrupt; the code triggers on any of the nine causes
// - record index 01h full, 00h first four
// - dictionary index 2F01h full, 2F00h four
// - module byte bits 0,2,3,4,7; rest zero
// - class byte 15h: analog, channel info
// - internal byte bit3 overflow, bit4 comm error
// - channel kind code reads 71h analog input
// - diagnostic bits per channel reads 08h
// - channel count reads 01h
// - summary bit 0 on channel 0 error
// - channel byte bits 0,3,6,7 as listed
// - record ends in 4-byte time stamp
// - stamp captures microsecond counter at event
// - microsecond counter from zero, wraps at 2^32-1
package sgd_pkg;
   // clock and time
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_US = 1;
   localparam int US_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;
   // record layout, byte offsets
   localparam int OFS_STAMP = 16;
   localparam logic [5:0] RECORD_LEN = 6'h14;
   localparam logic [5:0] SHORT_LEN = 6'h04;
   // access indices
   localparam logic [7:0] SET_SHORT = 8'h00;
   localparam logic [7:0] SET_FULL = 8'h01;
   localparam logic [15:0] OD_SHORT = 16'h2f00;
   localparam logic [15:0] OD_FULL = 16'h2f01;
   // constant bytes and reset values
   localparam logic [7:0] CLASS_RESET = 8'h15;
   localparam logic [7:0] SPARE_RESET = 8'h00;
   localparam logic [7:0] CHTYPE_AI = 8'h71;
   localparam logic [7:0] BITS_PER_CH = 8'h08;
   localparam logic [7:0] NUM_CH = 8'h01;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [31:0] STAMP_RESET = 32'h0000_0000;
   // module diagnostic byte bit positions
   localparam int MOD_FAIL_BIT = 0;
   localparam int MOD_EXT_BIT = 2;
   localparam int MOD_CHAN_BIT = 3;
   localparam int MOD_AUX_BIT = 4;
   localparam int MOD_PARAM_BIT = 7;
   // internal diagnostic byte bit positions
   localparam int INT_OVF_BIT = 3;
   localparam int INT_COMM_BIT = 4;
   // channel error byte bit positions
   localparam int CH_PARAM_BIT = 0;
   localparam int CH_SHORT_BIT = 3;
   localparam int CH_UNDER_BIT = 6;
   localparam int CH_OVER_BIT = 7;
   // interrupt window states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACTIVE = 1'b1
   } sgd_state_type;
endpackage : sgd_pkg
